/* File: lb_defines.svh */
`ifndef LB_DEFINES_SVH
`define LB_DEFINES_SVH

// command/indicate codes seen on the backplane control channel
`define CI_ACT_REQ_LOOP 4'h8
`define CI_RESET_CMD 4'h1
`define CI_LOOP_IND 4'he
`define CI_WIDTH 4

// message prefixes (first byte of a two-byte monitor message)
`define MSG_OPS_PREFIX 8'h01
`define MSG_LOCAL_PREFIX 8'h80

// operations channel loop-back codes
`define OPS_COMPLETE_LOOP 8'h50
`define OPS_FIRST_B_LOOP 8'h51
`define OPS_SECOND_B_LOOP 8'h52
`define OPS_RETURN_NORMAL 8'hff

// local monitor loop-back codes
`define LOCAL_COMPLETE_LOOP 8'hf1
`define LOCAL_FIRST_B_LOOP 8'hf2
`define LOCAL_SECOND_B_LOOP 8'hf4
`define LOCAL_NORMAL 8'hff

// channel slots inside one frame
`define CH_B1 0
`define CH_B2 1
`define CH_D 2
`define CH_COUNT 3
`define CH_BITS 8

// reset values
`define RST_CODE 8'h00
`define RST_CI 4'h0
`define RST_FRAME 24'h000000

`endif

/* File: lb_pkg.sv */
package lb_pkg;

	typedef enum logic [1:0] {
		MODE_LT,
		MODE_LT_REPEATER,
		MODE_NT,
		MODE_NT_REPEATER
	} mode_e;

	typedef enum logic [2:0] {
		ST_TEST,
		ST_DEACTIVATED,
		ST_LINE_ACTIVE,
		ST_TRANSPARENT,
		ST_ANALOG_LOOP,
		ST_OTHER
	} line_state_e;

	// one frame: b1, b2 and d slot (d uses the low two bits)
	typedef struct packed {
		logic [2:0][7:0] ch;
	} frame_s;

	typedef struct packed {
		logic [7:0] prefix;
		logic [7:0] code;
	} msg_s;

	// decoded loop-back requests, one-cycle pulses
	typedef struct packed {
		logic close_b1;
		logic close_b2;
		logic complete_ops;
		logic complete_local;
		logic open_all;
	} cmd_s;

	typedef enum logic {
		AL_OPEN,
		AL_CLOSED
	} analog_state_e;

endpackage

/* File: lb_cmd_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lb_defines.svh"

module lb_cmd_decode
	import lb_pkg::*;
(
	input wire logic nt_side,
	input wire logic eoc_auto,
	input wire logic ops_valid,
	input wire logic [7:0] ops_code,
	input wire logic mon_valid,
	input var msg_s mon_msg,
	output cmd_s cmd
);

	logic local_ok;

	// local messages must carry the local prefix
	assign local_ok = mon_valid && (mon_msg.prefix == `MSG_LOCAL_PREFIX) && nt_side;

	// auto mode takes operations codes, transparent mode takes local codes
	always_comb begin
		cmd = '0;
		if (nt_side && eoc_auto && ops_valid) begin
			cmd.close_b1 = (ops_code == `OPS_FIRST_B_LOOP);
			cmd.close_b2 = (ops_code == `OPS_SECOND_B_LOOP);
			cmd.complete_ops = (ops_code == `OPS_COMPLETE_LOOP);
			cmd.open_all = (ops_code == `OPS_RETURN_NORMAL);
		end
		if (local_ok) begin
			// complete code is decoded in both modes; the top gates it in auto mode
			cmd.complete_local = (mon_msg.code == `LOCAL_COMPLETE_LOOP);
			if (!eoc_auto) begin
				cmd.close_b1 = (mon_msg.code == `LOCAL_FIRST_B_LOOP);
				cmd.close_b2 = (mon_msg.code == `LOCAL_SECOND_B_LOOP);
				cmd.open_all = cmd.open_all || (mon_msg.code == `LOCAL_NORMAL);
			end
		end
	end

endmodule // lb_cmd_decode
`default_nettype wire

/* File: lb_loop_mux.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lb_defines.svh"

module lb_loop_mux
	import lb_pkg::*;
(
	input var frame_s normal,
	input var frame_s looped,
	input wire logic [2:0] sel,
	output frame_s out
);

	// per-channel select between normal path and loop path
	genvar i;
	generate
		for (i = 0; i < `CH_COUNT; i++) begin : g_ch
			assign out.ch[i] = sel[i] ? looped.ch[i] : normal.ch[i];
		end
	endgenerate

endmodule // lb_loop_mux
`default_nettype wire

/* File: loopback_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lb_defines.svh"

module loopback_control
	import lb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input var mode_e mode,
	input var line_state_e line_state,
	input wire logic eoc_auto,
	input wire logic ci_rx_valid,
	input wire logic [3:0] ci_rx_code,
	input wire logic mon_rx_valid,
	input var msg_s mon_rx_msg,
	input wire logic monitor_receive_handshake_in,
	input wire logic monitor_transmit_handshake_in,
	input wire logic ops_rx_valid,
	input wire logic [7:0] ops_rx_code,
	input wire logic frame_stb,
	input var frame_s bp_frame_in,
	input var frame_s line_rx_frame,
	output logic ci_fwd_valid,
	output logic [3:0] ci_fwd_code,
	output logic mon_fwd_valid,
	output msg_s mon_fwd_msg,
	output logic monitor_receive_handshake_out,
	output logic monitor_transmit_handshake_out,
	output logic ops_echo_valid,
	output logic [7:0] ops_echo_code,
	output logic ci_down_valid,
	output logic [3:0] ci_down_code,
	output frame_s line_tx_frame,
	output frame_s bp_frame_out,
	output frame_s core_rx_frame,
	output logic analog_closed,
	output logic hold_line_active,
	output logic hold_transparent,
	output logic hold_analog_state,
	output logic reconverge_pending,
	output logic loop_b1,
	output logic loop_b2,
	output logic loop_complete,
	output logic complete_pending
);

	logic lt_side;
	logic nt_side;
	logic ci_close_analog;
	logic ci_reset;
	logic close_allowed;
	logic local_complete_ok;
	logic is_loop_ops;
	logic [2:0] loop_sel;
	cmd_s cmd;
	analog_state_e analog_state;
	frame_s core_rx;
	frame_s tx_next;

	// mode grouping
	assign lt_side = (mode == MODE_LT) || (mode == MODE_LT_REPEATER);
	assign nt_side = (mode == MODE_NT) || (mode == MODE_NT_REPEATER);

	// controller command codes, decoded from the control channel
	assign ci_close_analog = ci_rx_valid && (ci_rx_code == `CI_ACT_REQ_LOOP);
	assign ci_reset = ci_rx_valid && (ci_rx_code == `CI_RESET_CMD);

	// close only from the required starting state on each side
	always_comb begin
		close_allowed = 1'b0;
		if (lt_side) begin
			close_allowed = (line_state == ST_DEACTIVATED);
		end else begin
			close_allowed = (line_state == ST_TEST);
		end
	end

	lb_cmd_decode u_decode (
		.nt_side(nt_side),
		.eoc_auto(eoc_auto),
		.ops_valid(ops_rx_valid),
		.ops_code(ops_rx_code),
		.mon_valid(mon_rx_valid),
		.mon_msg(mon_rx_msg),
		.cmd(cmd)
	);

	// analog loop (1, 1A, 3) state
	// the controller is expected to reset before closing; a close in the
	// wrong state is dropped rather than queued, so a late state change
	// cannot close a loop by surprise
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			analog_state <= AL_OPEN;
		end else begin
			case (analog_state)
				AL_OPEN: begin
					if (ci_close_analog && close_allowed) begin
						analog_state <= AL_CLOSED;
					end
				end
				AL_CLOSED: begin
					if (ci_reset) begin
						analog_state <= AL_OPEN;
					end
				end
				default: begin
					analog_state <= AL_OPEN;
				end
			endcase
		end
	end

	assign analog_closed = (analog_state == AL_CLOSED);

	// state holds requested of the surrounding state machine
	always_comb begin
		hold_line_active = 1'b0;
		hold_transparent = 1'b0;
		hold_analog_state = 1'b0;
		if (analog_closed) begin
			case (mode)
				MODE_LT: begin
					hold_line_active = 1'b1;
				end
				MODE_LT_REPEATER: begin
					// repeater loop 1A is closed on this end too
					hold_line_active = 1'b1;
					hold_transparent = 1'b1;
				end
				MODE_NT, MODE_NT_REPEATER: begin
					hold_analog_state = 1'b1;
				end
				default: begin
					hold_line_active = 1'b0;
				end
			endcase
		end
	end

	// coefficients must retrain after any reset, pin or command
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reconverge_pending <= 1'b1;
		end else if (ci_reset) begin
			reconverge_pending <= 1'b1;
		end else if (line_state == ST_LINE_ACTIVE || line_state == ST_TRANSPARENT) begin
			reconverge_pending <= 1'b0;
		end
	end

	// memory of an operations complete command, needed by auto mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			complete_pending <= 1'b0;
		end else if (cmd.complete_ops) begin
			// a new command wins over a same-cycle open
			complete_pending <= 1'b1;
		end else if (cmd.open_all) begin
			complete_pending <= 1'b0;
		end
	end

	// local complete message acceptance differs between modes
	always_comb begin
		if (eoc_auto) begin
			local_complete_ok = cmd.complete_local && complete_pending;
		end else begin
			local_complete_ok = cmd.complete_local;
		end
	end

	// latched loop 2 selections; open_all has no effect on line state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_b1 <= 1'b0;
		end else if (cmd.close_b1) begin
			loop_b1 <= 1'b1;
		end else if (cmd.open_all) begin
			loop_b1 <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_b2 <= 1'b0;
		end else if (cmd.close_b2) begin
			loop_b2 <= 1'b1;
		end else if (cmd.open_all) begin
			loop_b2 <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loop_complete <= 1'b0;
		end else if (local_complete_ok) begin
			loop_complete <= 1'b1;
		end else if (cmd.open_all) begin
			loop_complete <= 1'b0;
		end
	end

	// mirror loop messages at once in auto mode; this is no proof of success
	assign is_loop_ops = (ops_rx_code == `OPS_FIRST_B_LOOP) ||
		(ops_rx_code == `OPS_SECOND_B_LOOP) ||
		(ops_rx_code == `OPS_COMPLETE_LOOP) ||
		(ops_rx_code == `OPS_RETURN_NORMAL);

	// echo strobe: loop codes only, and only when operations are handled here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ops_echo_valid <= 1'b0;
		end else begin
			ops_echo_valid <= nt_side && eoc_auto && ops_rx_valid && is_loop_ops;
		end
	end

	// echo data follow every received code; only the strobe qualifies them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ops_echo_code <= `RST_CODE;
		end else if (ops_rx_valid) begin
			ops_echo_code <= ops_rx_code;
		end
	end

	// downstream request for the complete loop instead of closing it here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ci_down_valid <= 1'b0;
			ci_down_code <= `RST_CI;
		end else begin
			ci_down_valid <= cmd.complete_ops;
			if (cmd.complete_ops) begin
				if (line_state == ST_TRANSPARENT) begin
					ci_down_code <= `CI_LOOP_IND;
				end else begin
					ci_down_code <= `CI_ACT_REQ_LOOP;
				end
			end
		end
	end

	// control codes pass whatever loops are closed,
	// so layer 2 can still deactivate the line
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ci_fwd_valid <= 1'b0;
			ci_fwd_code <= `RST_CI;
		end else begin
			ci_fwd_valid <= ci_rx_valid;
			ci_fwd_code <= ci_rx_code;
		end
	end

	// monitor messages keep flowing too; copied whole, never filtered here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mon_fwd_valid <= 1'b0;
			mon_fwd_msg <= '0;
		end else begin
			mon_fwd_valid <= mon_rx_valid;
			mon_fwd_msg <= mon_rx_msg;
		end
	end

	// handshake bits rest high in reset, the idle level of the bus
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			monitor_receive_handshake_out <= 1'b1;
			monitor_transmit_handshake_out <= 1'b1;
		end else begin
			monitor_receive_handshake_out <= monitor_receive_handshake_in;
			monitor_transmit_handshake_out <= monitor_transmit_handshake_in;
		end
	end

	// receive side: analog loop replaces the line with our own transmit
	// signal, the latest frame held in line_tx_frame
	always_comb begin
		if (analog_closed) begin
			core_rx = line_tx_frame;
		end else begin
			core_rx = line_rx_frame;
		end
	end

	// channel loop: backplane output data feed the line-bound slots
	assign loop_sel[`CH_B1] = loop_b1 || loop_complete;
	assign loop_sel[`CH_B2] = loop_b2 || loop_complete;
	assign loop_sel[`CH_D] = loop_complete;

	lb_loop_mux u_mux (
		.normal(bp_frame_in),
		.looped(core_rx),
		.sel(loop_sel),
		.out(tx_next)
	);

	// frame registers, updated once per frame strobe
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_tx_frame <= `RST_FRAME;
			bp_frame_out <= `RST_FRAME;
			core_rx_frame <= `RST_FRAME;
		end else if (frame_stb) begin
			// transmitter keeps running under an analog loop so a far end wakes
			line_tx_frame <= tx_next;
			// looped data still leave on the normal backplane path
			bp_frame_out <= core_rx;
			core_rx_frame <= core_rx;
		end
	end

endmodule // loopback_control
`default_nettype wire

/* File: line_test_loopback_control_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lb_defines.svh"

module lb_chk
	import lb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input var mode_e mode,
	input var line_state_e line_state,
	input wire logic eoc_auto,
	input wire logic ci_rx_valid,
	input wire logic [3:0] ci_rx_code,
	input wire logic mon_rx_valid,
	input wire logic ops_rx_valid,
	input wire logic [7:0] ops_rx_code,
	input wire logic frame_stb,
	input var frame_s line_tx_frame,
	input var frame_s core_rx_frame,
	input wire logic ci_fwd_valid,
	input wire logic [3:0] ci_fwd_code,
	input wire logic ops_echo_valid,
	input wire logic [7:0] ops_echo_code,
	input wire logic ci_down_valid,
	input wire logic [3:0] ci_down_code,
	input wire logic analog_closed,
	input wire logic loop_b1,
	input wire logic loop_b2,
	input wire logic loop_complete
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// network side with automatic operations handling
	wire auto_nt = eoc_auto && mode[1];
	wire ops_req = ops_rx_valid && auto_nt;

	property p_fwd;
		ci_rx_valid |=> ci_fwd_valid && ci_fwd_code == $past(ci_rx_code);
	endproperty
	a_fwd: assert property (p_fwd) else $error("control code not forwarded");
	property p_b1;
		ops_req && ops_rx_code == 8'h51 |=> loop_b1;
	endproperty
	a_b1: assert property (p_b1) else $error("first channel not looped");
	property p_echo;
		ops_req && ops_rx_code inside {8'h50, 8'h51, 8'h52}
			|=> ops_echo_valid && ops_echo_code == $past(ops_rx_code);
	endproperty
	a_echo: assert property (p_echo) else $error("loop code not mirrored");
	property p_down;
		ops_req && ops_rx_code == 8'h50 |=> ci_down_valid &&
			ci_down_code == ($past(line_state) == ST_TRANSPARENT ? 4'he : 4'h8);
	endproperty
	a_down: assert property (p_down) else $error("wrong downstream request");
	property p_open;
		ops_req && ops_rx_code == 8'hff && !mon_rx_valid
			|=> !(loop_b1 || loop_b2 || loop_complete);
	endproperty
	a_open: assert property (p_open) else $error("loops still closed");
	property p_rst;
		$rose(rst_n) |-> !(loop_b1 || loop_b2 || loop_complete || analog_closed);
	endproperty
	a_rst: assert property (p_rst) else $error("loop survived reset");
	property p_close_state;
		ci_rx_valid && ci_rx_code == 4'h8 && mode == MODE_NT && !analog_closed
			|=> analog_closed == ($past(line_state) == ST_TEST);
	endproperty
	a_close_state: assert property (p_close_state) else $error("analog close from wrong state");
	property p_keep;
		analog_closed && !(ci_rx_valid && ci_rx_code == 4'h1) |=> analog_closed;
	endproperty
	a_keep: assert property (p_keep) else $error("analog loop opened early");
	property p_ana;
		analog_closed && frame_stb |=> core_rx_frame == $past(line_tx_frame);
	endproperty
	a_ana: assert property (p_ana) else $error("line data not ignored");
endmodule // lb_chk

bind loopback_control lb_chk u_chk (.*);
`default_nettype wire

/* File: lb_l2_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lb_l2_model
	import lb_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input var frame_s pat,
	output logic frame_stb,
	output frame_s bp_frame,
	output logic recv_hs,
	output logic xmit_hs
);
	logic [1:0] cnt;

	// one frame every four clocks; handshakes keep moving under loops
	always_ff @(posedge clk) begin
		cnt <= rst_n ? cnt + 2'h1 : 2'h0;
		frame_stb <= rst_n && cnt == 2'h3;
		bp_frame <= (cnt == 2'h3) ? pat : bp_frame;
		recv_hs <= rst_n ? recv_hs ^ frame_stb : 1'b1;
		xmit_hs <= rst_n ? cnt[1] : 1'b1;
	end
endmodule // lb_l2_model
`default_nettype wire

/* File: line_test_loopback_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module line_test_loopback_control_tb
	import lb_pkg::*;
;
	logic clk = 0, rst_n = 0, eoc_auto = 1, ci_rx_valid = 0, mon_rx_valid = 0, ops_rx_valid = 0;
	mode_e mode = MODE_NT;
	line_state_e line_state = ST_TEST;
	logic [3:0] ci_rx_code = 0, ci_fwd_code, ci_down_code;
	logic [7:0] ops_rx_code = 0, ops_echo_code;
	msg_s mon_rx_msg = 0;
	logic frame_stb, recv_hs, xmit_hs, ci_fwd_valid, ops_echo_valid, ci_down_valid, analog_closed;
	logic mon_fwd_valid, hs_rx_out, hs_tx_out, complete_pending;
	logic [1:0] hs_prev;
	msg_s mon_fwd_msg;
	logic [15:0] mq[$];
	logic hold_line_active, hold_transparent, hold_analog_state, reconverge_pending;
	logic loop_b1, loop_b2, loop_complete;
	frame_s bp_frame_in, line_tx_frame, bp_frame_out, core_rx_frame, r, p;
	frame_s line_rx_frame = 0, pat = 0;
	int failures = 0, n_tests = 0;
	logic [31:0] st = 24;
	logic [7:0] eq[$];
	logic [3:0] dq[$], fq[$];
	wire [3:0] lv = {loop_b1, loop_b2, loop_complete, analog_closed};

	lb_l2_model l2 (.clk, .rst_n, .pat, .frame_stb, .bp_frame(bp_frame_in), .recv_hs,
		.xmit_hs);
	loopback_control DUT (.clk, .rst_n, .mode, .line_state, .eoc_auto, .ci_rx_valid,
		.ci_rx_code, .mon_rx_valid, .mon_rx_msg, .monitor_receive_handshake_in(recv_hs),
		.monitor_transmit_handshake_in(xmit_hs), .ops_rx_valid, .ops_rx_code, .frame_stb,
		.bp_frame_in, .line_rx_frame, .ci_fwd_valid, .ci_fwd_code, .mon_fwd_valid,
		.mon_fwd_msg, .monitor_receive_handshake_out(hs_rx_out),
		.monitor_transmit_handshake_out(hs_tx_out),
		.ops_echo_valid, .ops_echo_code, .ci_down_valid, .ci_down_code, .line_tx_frame,
		.bp_frame_out, .core_rx_frame, .analog_closed, .hold_line_active, .hold_transparent,
		.hold_analog_state, .reconverge_pending, .loop_b1, .loop_b2, .loop_complete,
		.complete_pending);

	initial forever #25 clk = ~clk;

	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	// one request pulse; k 0 operations, 1 local monitor, 2 control code
	task req(input int k, input logic [15:0] v);
		@(posedge clk);
		if (k == 0) begin
			ops_rx_valid <= 1'b1;
			ops_rx_code <= v[7:0];
			if (eoc_auto && mode[1] && v[7:0] inside {8'h50, 8'h51, 8'h52, 8'hff})
				eq.push_back(v[7:0]);
			if (eoc_auto && mode[1] && v[7:0] == 8'h50) dq.push_back(
				line_state == ST_TRANSPARENT ? 4'he : 4'h8);
		end else if (k == 1) begin
			mon_rx_valid <= 1'b1;
			mon_rx_msg <= v;
			mq.push_back(v);
		end else begin
			ci_rx_valid <= 1'b1;
			ci_rx_code <= v[3:0];
			fq.push_back(v[3:0]);
		end
		@(posedge clk);
		ops_rx_valid <= 1'b0;
		mon_rx_valid <= 1'b0;
		ci_rx_valid <= 1'b0;
		#1;
	endtask

	// fresh line and backplane data; d-channel spare bits kept equal
	task newf;
		@(posedge clk);
		st = xs(st);
		p = st[23:0];
		st = xs(st);
		r = {p[23:18], st[17:0]};
		line_rx_frame <= r;
		pat <= p;
	endtask

	task frm(input frame_s tx, input frame_s core);
		repeat (12) @(posedge clk);
		#1;
		chk(line_tx_frame, tx);
		chk(core_rx_frame, core);
		chk(bp_frame_out, core);
	endtask

	task analog_run(input mode_e m, input line_state_e s, input logic e);
		@(posedge clk);
		mode <= m;
		line_state <= s;
		req(2, 16'h1);
		req(2, 16'h8);
		chk(24'(analog_closed), 24'(e));
		if (e) begin
			chk(24'({hold_line_active, hold_transparent, hold_analog_state}), 24'({m ==
				MODE_LT || m == MODE_LT_REPEATER, m == MODE_LT_REPEATER, m == MODE_NT}));
			newf;
			frm(p, p);
		end
		req(2, 16'h1);
		chk(24'(analog_closed), 0);
	endtask

	// pulses checked against the oldest note; stray pulses meet x
	always @(negedge clk) begin
		if (rst_n && ops_echo_valid === 1'b1)
			chk(24'(ops_echo_code), 24'(eq.size() ? eq.pop_front() : 8'hxx));
		if (rst_n && mon_fwd_valid === 1'b1)
			chk(24'(mon_fwd_msg), 24'(mq.size() ? mq.pop_front() : 16'hxxxx));
		if (rst_n)
			chk(24'({hs_rx_out, hs_tx_out}), 24'(hs_prev));
		hs_prev = {recv_hs, xmit_hs};
		if (rst_n && ci_down_valid === 1'b1)
			chk(24'(ci_down_code), 24'(dq.size() ? dq.pop_front() : 4'hx));
		if (rst_n && ci_fwd_valid === 1'b1)
			chk(24'(ci_fwd_code), 24'(fq.size() ? fq.pop_front() : 4'hx));
	end

	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		stop_test;
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		req(0, 16'h51);
		req(0, 16'h52);
		chk(24'(lv), 24'hc);
		newf;
		frm({p.ch[2], r.ch[1], r.ch[0]}, r);
		req(0, 16'hff);
		chk(24'(lv), 0);
		frm(p, r);
		req(1, 16'h80f2);
		req(1, 16'h80f1);
		chk(24'(lv), 0);
		@(posedge clk) line_state <= ST_TRANSPARENT;
		req(0, 16'h50);
		@(posedge clk) line_state <= ST_OTHER;
		req(0, 16'h50);
		chk(24'(lv), 0);
		chk(24'(complete_pending), 1);
		req(1, 16'h80f1);
		chk(24'(lv), 24'h2);
		frm(r, r);
		@(posedge clk) eoc_auto <= 1'b0;
		req(1, 16'h80ff);
		chk(24'(lv), 0);
		chk(24'(complete_pending), 0);
		req(0, 16'h51);
		req(1, 16'h80f1);
		req(1, 16'h80f2);
		req(1, 16'h80f4);
		chk(24'(lv), 24'he);
		// reset in mid-run with three loops latched
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(24'(lv), 0);
		chk(24'(reconverge_pending), 1);
		analog_run(MODE_LT, ST_OTHER, 0);
		analog_run(MODE_LT, ST_DEACTIVATED, 1);
		analog_run(MODE_NT, ST_DEACTIVATED, 0);
		analog_run(MODE_NT, ST_TEST, 1);
		analog_run(MODE_LT_REPEATER, ST_DEACTIVATED, 1);
		repeat (4) @(posedge clk);
		chk(24'(eq.size() + dq.size() + fq.size() + mq.size()), 0);
		stop_test;
	end
endmodule // line_test_loopback_control_tb
`default_nettype wire
